//--- dv/btap_master.sv
// test bus master model driving the test port
`timescale 1ns/1ns
module btap_master (
   // driven test bus
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   // serial return
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   ////////////////////////////////////////////////////////////////////////////////
   // clock stands low between frames; data lines rest at pull-up level
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // floating return reads as unknown so nothing passes by luck
   task automatic step(input logic m, input logic d, output logic so);
      tms = m;
      tdi = d;
      #3;
      so  = tdo_oe ? tdo : 1'bx;
      tck = 1'b1;
      #3;
      tck = 1'b0;
   endtask
   task automatic move(input logic m);
      logic so;
      step(m, 1'b1, so);
   endtask
   // from idle to idle; 0 < brk < n parks in pause after brk bits
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       input int brk, output logic [63:0] dout);
      logic so;
      dout = '0;
      move(1'b1);
      if (ir) begin
         move(1'b1);
      end
      move(1'b0);
      move(1'b0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || i == brk - 1, din[i], so);
         dout[i] = so;
         if (i == brk - 1 && i < n - 1) begin
            move(1'b0);
            move(1'b0);
            move(1'b1);
            move(1'b0);
         end
      end
      move(1'b1);
      move(1'b0);
   endtask
endmodule // btap_master

//--- dv/btap_top_asserts.sv
// concurrent checks on the test port controller, pins only
`timescale 1ns/1ns
module btap_top_asserts #(
   parameter logic [7:0] OP_RUNT     = 8'h09,
   parameter logic [7:0] OP_BCR_SCAN = 8'h87
) (
   // clocks and reset
   input wire logic                        mclk,
   input wire logic                        rstn,
   input wire logic                        tck,
   // test port
   input wire logic                        tms,
   input wire logic                        tdi,
   input wire logic                        tdo,
   input wire logic                        tdo_oe,
   // chains and status
   input wire logic [btap_pkg::BSR_W-1:0] bsr_capture_in,
   input wire logic [btap_pkg::BSR_W-1:0] bsr_latch,
   input wire logic [btap_pkg::BCR_W-1:0] bcr_latch,
   input wire logic [btap_pkg::IR_W-1:0]  instr_current,
   input wire logic                        test_mode,
   input wire logic                        ops_active
);
   ////////////////////////////////////////////////////////////////////////////////
   // one nibble per state: next state for mode-select low and high
   localparam logic [63:0] NXT0 = 64'h1bdd_bba1_4664_4311;
   localparam logic [63:0] NXT1 = 64'h2fef_cc02_8785_5920;
   btap_pkg::btap_state_t st_ff;
   btap_pkg::btap_state_t nxt_st;
   logic                  in_shift;
   assign nxt_st   = btap_pkg::btap_state_t'(tms ? NXT1[{st_ff, 2'b00} +: 4]
                                                 : NXT0[{st_ff, 2'b00} +: 4]);
   assign in_shift = st_ff == btap_pkg::ST_SHIFT_DR || st_ff == btap_pkg::ST_SHIFT_IR;
   always_ff @(posedge tck) begin
      if (!rstn) begin
         st_ff <= btap_pkg::ST_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_oe_shift;
      @(posedge tck) disable iff (!rstn) tdo_oe == in_shift;
   endproperty
   a_oe_shift: assert property (p_oe_shift)
      else $error("serial enable disagrees with shift state");
   property p_tdo_quiet;
      @(posedge tck) disable iff (!rstn) !tdo_oe |-> !tdo;
   endproperty
   a_tdo_quiet: assert property (p_tdo_quiet)
      else $error("serial output active while disabled");
   property p_ir_first;
      @(posedge tck) disable iff (!rstn)
         (st_ff == btap_pkg::ST_SHIFT_IR && $past(st_ff) == btap_pkg::ST_CAPTURE_IR)
         |-> tdo ##1 !tdo;
   endproperty
   a_ir_first: assert property (p_ir_first)
      else $error("instruction capture pattern wrong");
   property p_rst_ir;
      @(posedge tck) disable iff (!rstn) tms [*5] |=> instr_current == 8'hff;
   endproperty
   a_rst_ir: assert property (p_rst_ir)
      else $error("instruction not all ones after reset walk");
   property p_rst_bsr;
      @(posedge tck) disable iff (!rstn) tms [*5] |=> bsr_latch == 40'h00_0000_0000;
   endproperty
   a_rst_bsr: assert property (p_rst_bsr)
      else $error("boundary latches not cleared");
   property p_rst_bcr;
      @(posedge tck) disable iff (!rstn) tms [*5] |=> bcr_latch == 11'h002;
   endproperty
   a_rst_bcr: assert property (p_rst_bcr)
      else $error("control latches not at reset value");
   property p_bsr_hold;
      @(posedge tck) disable iff (!rstn)
         !(st_ff inside {btap_pkg::ST_UPDATE_DR, btap_pkg::ST_RESET}) |-> $stable(bsr_latch);
   endproperty
   a_bsr_hold: assert property (p_bsr_hold)
      else $error("boundary latches changed outside update");
   property p_bcr_hold;
      @(posedge tck) disable iff (!rstn)
         !(st_ff inside {btap_pkg::ST_UPDATE_DR, btap_pkg::ST_RESET}) |-> $stable(bcr_latch);
   endproperty
   a_bcr_hold: assert property (p_bcr_hold)
      else $error("control latches changed outside update");
   property p_ir_hold;
      @(posedge tck) disable iff (!rstn)
         !(st_ff inside {btap_pkg::ST_UPDATE_IR, btap_pkg::ST_RESET}) |-> $stable(instr_current);
   endproperty
   a_ir_hold: assert property (p_ir_hold)
      else $error("instruction changed outside update");
   property p_ops_runt;
      @(posedge mclk) disable iff (!rstn) $rose(ops_active) |-> instr_current == OP_RUNT;
   endproperty
   a_ops_runt: assert property (p_ops_runt)
      else $error("operations active without run instruction");
   property p_mode_par;
      @(posedge mclk) disable iff (!rstn) $rose(test_mode) |-> !(^instr_current);
   endproperty
   a_mode_par: assert property (p_mode_par)
      else $error("test mode entered on odd parity");
   c_ir_update: cover property (@(posedge tck) st_ff == btap_pkg::ST_UPDATE_IR);
   c_pause: cover property (@(posedge tck) st_ff == btap_pkg::ST_PAUSE_DR);
   c_ops: cover property (@(posedge mclk) $rose(ops_active));
endmodule // btap_top_asserts

//--- dv/btap_top_tb.sv
// self-checking bench for the boundary-scan test port controller
`timescale 1ns/1ns
module btap_top_tb;
   localparam logic [7:0]  OPR    = 8'h09;
   localparam logic [7:0]  OPB    = 8'h87;
   localparam logic [39:0] BSR_IN = 40'hc3_5a96_0f1e;
   localparam logic [39:0] BSR_SH = 40'h3c_a569_f0e1;
   localparam logic [31:0] MODES  = 32'h0006_80ff;
   localparam logic [3:0]  TM_EXP = 4'b1100;
   logic                       mclk;
   logic                       rstn;
   logic                       tck;
   logic                       tms;
   logic                       tdi;
   logic                       tdo;
   logic                       tdo_oe;
   logic [btap_pkg::BSR_W-1:0] bsr_cap;
   logic [btap_pkg::BSR_W-1:0] bsr_latch;
   logic [btap_pkg::BCR_W-1:0] bcr_latch;
   logic [btap_pkg::IR_W-1:0]  instr_current;
   logic                       test_mode;
   logic                       ops_active;
   logic [63:0]                dout;
   int                         num_errors = 0;
   int                         samples_checked = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // opcode parameters stay at their defaults, mirrored by OPR and OPB
   btap_top btap_top_inst (
      .mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .bsr_capture_in(bsr_cap), .bsr_latch(bsr_latch),
      .bcr_latch(bcr_latch), .instr_current(instr_current), .test_mode(test_mode),
      .ops_active(ops_active));
   btap_master btap_master_inst (
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic ir_load(input logic [7:0] v);
      btap_master_inst.scan(1'b1, 8, {56'h0, v}, 0, dout);
      check("ir capture", dout, 64'h81);
   endtask
   // bounded cross-domain settling of the status levels
   task automatic settle();
      repeat (6) @(posedge mclk);
   endtask
   initial begin
      #50000;
      num_errors++;
      final_report();
   end
   initial begin
      rstn    = 1'b0;
      bsr_cap = '0;
      fork
         repeat (4) btap_master_inst.move(1'b1);
         repeat (6) @(posedge mclk);
      join
      #1 rstn = 1'b1;
      repeat (3) btap_master_inst.move(1'b1);
      btap_master_inst.move(1'b0);
      check("instr", 64'(instr_current), 64'hff);
      check("bsr latch", 64'(bsr_latch), 64'h0);
      check("bcr latch", 64'(bcr_latch), 64'h002);
      check("mode", 64'(test_mode), 64'h0);
      check("oe", 64'(tdo_oe), 64'h0);
      $display("test reset_values done");
      ir_load(8'h82);
      check("instr", 64'(instr_current), 64'h82);
      @(posedge mclk);
      #1 bsr_cap = BSR_IN;
      btap_master_inst.scan(1'b0, 40, 64'(BSR_SH), 17, dout);
      check("bsr out", dout, 64'(BSR_IN));
      check("bsr latch", 64'(bsr_latch), 64'(BSR_SH));
      $display("test boundary_scan done");
      for (int i = 0; i < 4; i++) begin
         ir_load(MODES[i*8 +: 8]);
         settle();
         check("mode", 64'(test_mode), 64'(TM_EXP[i]));
         if (i < 3) begin
            btap_master_inst.scan(1'b0, 8, 64'ha5, 0, dout);
            check("bypass out", dout, 64'h4a);
         end
      end
      $display("test modes_bypass done");
      ir_load(OPB);
      btap_master_inst.scan(1'b0, 11, 64'h5a5, 0, dout);
      check("bcr out", dout, 64'h002);
      check("bcr latch", 64'(bcr_latch), 64'h5a5);
      ir_load(OPR);
      repeat (2) btap_master_inst.move(1'b0);
      settle();
      check("ops", 64'(ops_active), 64'h1);
      btap_master_inst.move(1'b1);
      settle();
      check("ops", 64'(ops_active), 64'h0);
      $display("test control_ops done");
      repeat (2) btap_master_inst.move(1'b0);
      repeat (5) btap_master_inst.move(1'b1);
      // latches reset on the falling edge ending the last step; let it settle
      btap_master_inst.move(1'b0);
      check("instr", 64'(instr_current), 64'hff);
      check("bsr latch", 64'(bsr_latch), 64'h0);
      check("bcr latch", 64'(bcr_latch), 64'h002);
      settle();
      check("mode", 64'(test_mode), 64'h0);
      $display("test tms_reset done");
      final_report();
   end
endmodule // btap_top_tb

bind btap_top btap_top_asserts btap_top_asserts_inst (
   .mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
   .tdo_oe(tdo_oe), .bsr_capture_in(bsr_capture_in), .bsr_latch(bsr_latch),
   .bcr_latch(bcr_latch), .instr_current(instr_current), .test_mode(test_mode),
   .ops_active(ops_active));

//--- src/btap_chain.sv
// scan chain: shift stage with a holding latch per bit
`timescale 1ns/1ns
module btap_chain #(
   parameter int           W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   // test clock and chain reset
   input  wire logic         tck,
   input  wire logic         rst,
   // controls from the state machine
   input  wire logic         capture,
   input  wire logic         shift,
   input  wire logic         update,
   // data
   input  wire logic [W-1:0] cap_val,
   input  wire logic         si,
   output logic      [W-1:0] shift_q,
   output logic      [W-1:0] q
);

   logic [W-1:0] shift_ff;
   logic [W-1:0] latch_ff;

   // serial data enters the msb, lsb faces the serial output
   always_ff @(posedge tck) begin
      if (rst) begin
         shift_ff <= RST;
      end else if (capture) begin
         shift_ff <= cap_val;
      end else if (shift) begin
         shift_ff <= {si, shift_ff[W-1:1]};
      end
   end

   // holding latch moves only on the falling edge, in update or in reset
   always_ff @(negedge tck) begin
      if (rst) begin
         latch_ff <= RST;
      end else if (update) begin
         latch_ff <= shift_ff;
      end
   end

   assign shift_q = shift_ff;
   assign q       = latch_ff;

endmodule // btap_chain

//--- src/btap_pkg.sv
// constants, types and states of the boundary-scan test port
package btap_pkg;

   localparam int          IR_W          = 8;
   localparam int          BSR_W         = 40;
   localparam int          BCR_W         = 11;
   localparam int          SYNC_STAGES   = 2;

   localparam logic [7:0]  IR_RST        = 8'hff;
   localparam logic [7:0]  IR_CAPTURE    = 8'h81;
   localparam logic [39:0] BSR_RST       = 40'h00_0000_0000;
   localparam logic [10:0] BCR_RST       = 11'h002;
   localparam logic        BYP_CAPTURE   = 1'h0;

   localparam int          PARITY_BIT    = 7;
   localparam int          BCR_OP_MSB    = 2;
   localparam int          BCR_OP_LSB    = 0;

   // low seven opcode bits of the boundary instructions
   localparam logic [6:0]  OP_EXTEST     = 7'h00;
   localparam logic [6:0]  OP_SAMPLE     = 7'h02;
   localparam logic [6:0]  OP_INTEST     = 7'h03;
   localparam logic [6:0]  OP_HIGHZ      = 7'h06;

   typedef enum logic [3:0] {
      ST_RESET      = 4'h0,
      ST_IDLE       = 4'h1,
      ST_SEL_DR     = 4'h2,
      ST_CAPTURE_DR = 4'h3,
      ST_SHIFT_DR   = 4'h4,
      ST_EXIT1_DR   = 4'h5,
      ST_PAUSE_DR   = 4'h6,
      ST_EXIT2_DR   = 4'h7,
      ST_UPDATE_DR  = 4'h8,
      ST_SEL_IR     = 4'h9,
      ST_CAPTURE_IR = 4'ha,
      ST_SHIFT_IR   = 4'hb,
      ST_EXIT1_IR   = 4'hc,
      ST_PAUSE_IR   = 4'hd,
      ST_EXIT2_IR   = 4'he,
      ST_UPDATE_IR  = 4'hf
   } btap_state_t;

   typedef struct packed {
      logic sel_bsr;
      logic sel_bcr;
      logic test_mode;
      logic run_ops;
   } btap_decode_t;

endpackage : btap_pkg

//--- src/btap_sync.sv
// two-stage level synchroniser
`timescale 1ns/1ns
module btap_sync #(
   parameter int W = 1
) (
   // destination clock and clear
   input  wire logic         clk,
   input  wire logic         clr,
   // levels in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // first stage feeds the second stage only
   always_ff @(posedge clk) begin
      if (clr) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule // btap_sync

//--- src/btap_top.sv
// boundary-scan test port controller with its instruction and data chains
`timescale 1ns/1ns
module btap_top #(
   parameter logic [7:0] OP_RUNT     = 8'h09,
   parameter logic [7:0] OP_BCR_SCAN = 8'h87
) (
   // system clock domain
   input  wire logic                      mclk,
   input  wire logic                      rstn,
   // test port, all on the test clock
   input  wire logic                      tck,
   input  wire logic                      tms,
   input  wire logic                      tdi,
   output logic                           tdo,
   output logic                           tdo_oe,
   // boundary capture source, test clock domain
   input  wire logic [btap_pkg::BSR_W-1:0] bsr_capture_in,
   // latched chain contents, test clock domain
   output logic      [btap_pkg::BSR_W-1:0] bsr_latch,
   output logic      [btap_pkg::BCR_W-1:0] bcr_latch,
   output logic      [btap_pkg::IR_W-1:0]  instr_current,
   // status seen on the system clock
   output logic                           test_mode,
   output logic                           ops_active
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   btap_pkg::btap_state_t               state_ff;
   btap_pkg::btap_state_t               nxt_state;
   btap_pkg::btap_decode_t              dec;
   btap_pkg::btap_decode_t              dec_upd;
   logic                                tck_rstn_sync;
   logic                                hard_rst;
   logic                                chain_rst;
   logic [btap_pkg::IR_W-1:0]           ir_shift;
   logic [btap_pkg::IR_W-1:0]           ir_latch;
   logic [btap_pkg::BSR_W-1:0]          bsr_shift;
   logic [btap_pkg::BSR_W-1:0]          bsr_q;
   logic [btap_pkg::BCR_W-1:0]          bcr_shift;
   logic [btap_pkg::BCR_W-1:0]          bcr_q;
   logic                                bypass_ff;
   logic                                tdo_ff;
   logic                                tdo_oe_ff;
   logic                                idle_seen_ff;
   logic                                run_ops_ff;
   logic                                test_mode_tck_ff;
   logic [1:0]                          sys_sync;
   logic                                test_mode_ff;
   logic                                ops_active_ff;
   logic                                in_shift_dr;
   logic                                in_shift_ir;
   logic                                sel_bypass;
   logic                                nxt_tdo;

   ////////////////////////////////////////////////////////////////////////////
   // instruction decode
   function automatic btap_pkg::btap_decode_t decode(input logic [btap_pkg::IR_W-1:0] ir);
      btap_pkg::btap_decode_t d;
      logic [6:0]             low;
      d   = '0;
      low = ir[btap_pkg::PARITY_BIT-1:0];
      // odd parity or unknown code falls back to bypass
      if (~^ir) begin
         if (ir == OP_RUNT) begin
            d.run_ops = 1'b1;
         end else if (ir == OP_BCR_SCAN) begin
            d.sel_bcr = 1'b1;
         end else begin
            case (low)
               btap_pkg::OP_EXTEST,
               btap_pkg::OP_INTEST: begin
                  d.sel_bsr   = 1'b1;
                  d.test_mode = 1'b1;
               end
               btap_pkg::OP_SAMPLE: begin
                  d.sel_bsr   = 1'b1;
               end
               btap_pkg::OP_HIGHZ: begin
                  d.test_mode = 1'b1;
               end
               default: begin
                  d = '0;
               end
            endcase
         end
      end
      return d;
   endfunction

   // current instruction only changes on the update edge or on chain reset
   assign dec        = decode(ir_latch);
   assign sel_bypass = ~dec.sel_bsr & ~dec.sel_bcr;
   // latch and mode flag share the update edge, so look at the shift stage
   assign dec_upd    = (state_ff == btap_pkg::ST_UPDATE_IR) ? decode(ir_shift) : dec;

   ////////////////////////////////////////////////////////////////////////////
   // reset into the test clock domain
   // the test clock may stand still, so reset is seen only while it runs
   btap_sync #(
      .W (1)
   ) u_rst_sync (
      .clk (tck),
      .clr (1'b0),
      .d   (rstn),
      .q   (tck_rstn_sync)
   );

   assign hard_rst  = ~tck_rstn_sync;
   // chains reset in the reset state as well as on power-up
   assign chain_rst = hard_rst | (state_ff == btap_pkg::ST_RESET);

   ////////////////////////////////////////////////////////////////////////////
   // state machine
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         btap_pkg::ST_RESET: begin
            nxt_state = tms ? btap_pkg::ST_RESET : btap_pkg::ST_IDLE;
         end
         btap_pkg::ST_IDLE: begin
            nxt_state = tms ? btap_pkg::ST_SEL_DR : btap_pkg::ST_IDLE;
         end
         btap_pkg::ST_SEL_DR: begin
            nxt_state = tms ? btap_pkg::ST_SEL_IR : btap_pkg::ST_CAPTURE_DR;
         end
         btap_pkg::ST_CAPTURE_DR: begin
            nxt_state = tms ? btap_pkg::ST_EXIT1_DR : btap_pkg::ST_SHIFT_DR;
         end
         btap_pkg::ST_SHIFT_DR: begin
            nxt_state = tms ? btap_pkg::ST_EXIT1_DR : btap_pkg::ST_SHIFT_DR;
         end
         btap_pkg::ST_EXIT1_DR: begin
            nxt_state = tms ? btap_pkg::ST_UPDATE_DR : btap_pkg::ST_PAUSE_DR;
         end
         btap_pkg::ST_PAUSE_DR: begin
            nxt_state = tms ? btap_pkg::ST_EXIT2_DR : btap_pkg::ST_PAUSE_DR;
         end
         btap_pkg::ST_EXIT2_DR: begin
            nxt_state = tms ? btap_pkg::ST_UPDATE_DR : btap_pkg::ST_SHIFT_DR;
         end
         btap_pkg::ST_UPDATE_DR: begin
            nxt_state = tms ? btap_pkg::ST_SEL_DR : btap_pkg::ST_IDLE;
         end
         btap_pkg::ST_SEL_IR: begin
            nxt_state = tms ? btap_pkg::ST_RESET : btap_pkg::ST_CAPTURE_IR;
         end
         btap_pkg::ST_CAPTURE_IR: begin
            nxt_state = tms ? btap_pkg::ST_EXIT1_IR : btap_pkg::ST_SHIFT_IR;
         end
         btap_pkg::ST_SHIFT_IR: begin
            nxt_state = tms ? btap_pkg::ST_EXIT1_IR : btap_pkg::ST_SHIFT_IR;
         end
         btap_pkg::ST_EXIT1_IR: begin
            nxt_state = tms ? btap_pkg::ST_UPDATE_IR : btap_pkg::ST_PAUSE_IR;
         end
         btap_pkg::ST_PAUSE_IR: begin
            nxt_state = tms ? btap_pkg::ST_EXIT2_IR : btap_pkg::ST_PAUSE_IR;
         end
         btap_pkg::ST_EXIT2_IR: begin
            nxt_state = tms ? btap_pkg::ST_UPDATE_IR : btap_pkg::ST_SHIFT_IR;
         end
         btap_pkg::ST_UPDATE_IR: begin
            nxt_state = tms ? btap_pkg::ST_SEL_DR : btap_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = btap_pkg::ST_RESET;
         end
      endcase
   end

   // every tms-high path funnels into reset in five edges or fewer
   always_ff @(posedge tck) begin
      if (hard_rst) begin
         state_ff <= btap_pkg::ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign in_shift_dr = (state_ff == btap_pkg::ST_SHIFT_DR);
   assign in_shift_ir = (state_ff == btap_pkg::ST_SHIFT_IR);

   ////////////////////////////////////////////////////////////////////////////
   // instruction chain
   btap_chain #(
      .W   (btap_pkg::IR_W),
      .RST (btap_pkg::IR_RST)
   ) u_ir (
      .tck     (tck),
      .rst     (chain_rst),
      .capture (state_ff == btap_pkg::ST_CAPTURE_IR),
      .shift   (in_shift_ir),
      .update  (state_ff == btap_pkg::ST_UPDATE_IR),
      .cap_val (btap_pkg::IR_CAPTURE),
      .si      (tdi),
      .shift_q (ir_shift),
      .q       (ir_latch)
   );

   ////////////////////////////////////////////////////////////////////////////
   // boundary chain
   btap_chain #(
      .W   (btap_pkg::BSR_W),
      .RST (btap_pkg::BSR_RST)
   ) u_bsr (
      .tck     (tck),
      .rst     (chain_rst),
      .capture ((state_ff == btap_pkg::ST_CAPTURE_DR) & dec.sel_bsr),
      .shift   (in_shift_dr & dec.sel_bsr),
      .update  ((state_ff == btap_pkg::ST_UPDATE_DR) & dec.sel_bsr),
      .cap_val (bsr_capture_in),
      .si      (tdi),
      .shift_q (bsr_shift),
      .q       (bsr_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // test-operation control chain; capture keeps its own contents
   btap_chain #(
      .W   (btap_pkg::BCR_W),
      .RST (btap_pkg::BCR_RST)
   ) u_bcr (
      .tck     (tck),
      .rst     (chain_rst),
      .capture ((state_ff == btap_pkg::ST_CAPTURE_DR) & dec.sel_bcr),
      .shift   (in_shift_dr & dec.sel_bcr),
      .update  ((state_ff == btap_pkg::ST_UPDATE_DR) & dec.sel_bcr),
      .cap_val (bcr_shift),
      .si      (tdi),
      .shift_q (bcr_shift),
      .q       (bcr_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bypass stage: captures zero and shifts, no latch
   always_ff @(posedge tck) begin
      if (chain_rst) begin
         bypass_ff <= btap_pkg::BYP_CAPTURE;
      end else if ((state_ff == btap_pkg::ST_CAPTURE_DR) & sel_bypass) begin
         bypass_ff <= btap_pkg::BYP_CAPTURE;
      end else if (in_shift_dr & sel_bypass) begin
         bypass_ff <= tdi;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial output, changes on the falling edge only
   always_comb begin
      nxt_tdo = 1'b0;
      if (in_shift_ir) begin
         nxt_tdo = ir_shift[0];
      end else if (dec.sel_bsr) begin
         nxt_tdo = bsr_shift[0];
      end else if (dec.sel_bcr) begin
         nxt_tdo = bcr_shift[0];
      end else begin
         nxt_tdo = bypass_ff;
      end
   end

   // enable follows the state one half cycle late: drives from the first
   // falling edge in shift, floats from the first falling edge in exit1
   always_ff @(negedge tck) begin
      if (hard_rst) begin
         tdo_oe_ff <= 1'b0;
         tdo_ff    <= 1'b0;
      end else begin
         tdo_oe_ff <= in_shift_dr | in_shift_ir;
         tdo_ff    <= (in_shift_dr | in_shift_ir) ? nxt_tdo : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // test operations and mode, test clock side
   always_ff @(posedge tck) begin
      if (chain_rst) begin
         idle_seen_ff <= 1'b0;
      end else if (state_ff == btap_pkg::ST_IDLE) begin
         idle_seen_ff <= 1'b1;
      end
   end

   // operations run only while idle; leaving idle stops them on the next falling edge
   always_ff @(negedge tck) begin
      if (chain_rst) begin
         run_ops_ff       <= 1'b0;
         test_mode_tck_ff <= 1'b0;
      end else begin
         run_ops_ff       <= dec.run_ops & idle_seen_ff &
                             (state_ff == btap_pkg::ST_IDLE);
         test_mode_tck_ff <= dec_upd.test_mode | dec_upd.run_ops;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // crossing to the system clock, levels only
   btap_sync #(
      .W (2)
   ) u_sys_sync (
      .clk (mclk),
      .clr (~rstn),
      .d   ({test_mode_tck_ff, run_ops_ff}),
      .q   (sys_sync)
   );

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         test_mode_ff  <= 1'b0;
         ops_active_ff <= 1'b0;
      end else begin
         test_mode_ff  <= sys_sync[1];
         ops_active_ff <= sys_sync[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign tdo           = tdo_ff;
   assign tdo_oe        = tdo_oe_ff;
   assign bsr_latch     = bsr_q;
   assign bcr_latch     = bcr_q;
   assign instr_current = ir_latch;
   assign test_mode     = test_mode_ff;
   assign ops_active    = ops_active_ff;

endmodule // btap_top
